// >>> rtl/ctbe_exec.sv
// Execution slice for program-memory, stack, I/O, shift and flag operations
`timescale 1ns/1ps
module ctbe_exec
  import ctbe_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Program memory
  output ctbe_pm_req_t pm_req,
  input wire logic [7:0] pm_rdata,
  // Data stack
  output logic stk_push,
  output logic stk_pop,
  output logic [7:0] stk_wdata,
  input wire logic [7:0] stk_rdata,
  // I/O register space
  output ctbe_io_req_t io_req,
  input wire logic [7:0] io_rdata
);

  ctbe_state_t state_q;
  ctbe_cmd_t cmd_q;
  logic [2:0] cnt_q;
  logic [2:0] cyc_q;
  logic [7:0] operand_q;
  logic [7:0] result_q;
  logic [7:0] status_q;
  logic [15:0] zptr_q;
  logic [15:0] word_q;
  logic [5:0] ioaddr_q;
  logic [7:0] io_mod_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic [7:0] sh_res;
  logic sh_c;
  logic busy;
  logic last;
  logic acc;
  logic wr_acc;
  logic wr_ok;
  logic start;
  logic [4:0] wr_op;

  function automatic logic [2:0] op_cycles(input logic [4:0] op);
    case (op)
      OP_PROGMEM_BYTE_FETCH: op_cycles = CTBE_CYC_FETCH;
      OP_PROGMEM_WORD_WRITE: op_cycles = CTBE_CYC_WORD_WRITE;
      OP_STACK_STORE, OP_STACK_LOAD: op_cycles = CTBE_CYC_STACK;
      OP_IO_BIT_RAISE, OP_IO_BIT_DROP: op_cycles = CTBE_CYC_IO_BIT;
      default: op_cycles = CTBE_CYC_SINGLE;
    endcase
  endfunction

  // Status bit steered by each dedicated flag instruction
  function automatic logic [2:0] flag_sel(input logic [4:0] op);
    case (op)
      OP_CARRY_RAISE, OP_CARRY_DROP: flag_sel = 3'(CTBE_FLAG_C);
      OP_NEGATIVE_FLAG_RAISE, OP_NEGATIVE_FLAG_DROP: flag_sel = 3'(CTBE_FLAG_N);
      OP_ZERO_FLAG_RAISE, OP_ZERO_FLAG_DROP: flag_sel = 3'(CTBE_FLAG_Z);
      OP_IRQ_GLOBAL_ALLOW, OP_IRQ_GLOBAL_BLOCK: flag_sel = 3'(CTBE_FLAG_I);
      OP_SIGN_FLAG_RAISE, OP_SIGN_FLAG_DROP: flag_sel = 3'(CTBE_FLAG_S);
      OP_OVERFLOW_FLAG_RAISE, OP_OVERFLOW_FLAG_DROP: flag_sel = 3'(CTBE_FLAG_V);
      default: flag_sel = 3'(CTBE_FLAG_T);
    endcase
  endfunction

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    case (8'(a))
      CTBE_CMD_OFS, CTBE_OPERAND_OFS, CTBE_RESULT_OFS, CTBE_STATUS_OFS,
      CTBE_ZPTR_OFS, CTBE_WORD_OFS, CTBE_IOADDR_OFS: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  assign busy = (state_q == CTBE_ST_EXEC);
  assign last = busy && (cnt_q == cyc_q - 3'h1);
  assign acc = psel && penable;
  assign wr_op = pwdata[CTBE_CMD_OP_LSB +: 5];

  // Writes are refused while executing, to the result word and with code zero
  always_comb begin
    wr_ok = 1'b0;
    if (!busy && addr_mapped(paddr) && (8'(paddr) != CTBE_RESULT_OFS)) begin
      wr_ok = (8'(paddr) != CTBE_CMD_OFS) || (wr_op != 5'h00);
    end
  end

  assign wr_acc = acc && pwrite && wr_ok;
  assign start = wr_acc && (8'(paddr) == CTBE_CMD_OFS);
  assign pready = 1'b1;
  assign pslverr = acc && (pwrite ? !wr_ok : !addr_mapped(paddr));

  always_comb begin
    case (8'(paddr))
      CTBE_CMD_OFS: rd_mux = {busy, 20'h00000, cmd_q.bit_idx, 3'h0, cmd_q.op};
      CTBE_OPERAND_OFS: rd_mux = {24'h000000, operand_q};
      CTBE_RESULT_OFS: rd_mux = {24'h000000, result_q};
      CTBE_STATUS_OFS: rd_mux = {24'h000000, status_q};
      CTBE_ZPTR_OFS: rd_mux = {16'h0000, zptr_q};
      CTBE_WORD_OFS: rd_mux = {16'h0000, word_q};
      CTBE_IOADDR_OFS: rd_mux = {26'h0000000, ioaddr_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Read data is captured in the setup cycle and held through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;

  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= CTBE_ST_IDLE;
      cmd_q <= '0;
      cnt_q <= 3'h0;
      cyc_q <= 3'h1;
    end else begin
      case (state_q)
        CTBE_ST_IDLE: begin
          if (start) begin
            state_q <= CTBE_ST_EXEC;
            cmd_q.op <= wr_op;
            cmd_q.bit_idx <= pwdata[CTBE_CMD_BIT_LSB +: 3];
            cnt_q <= 3'h0;
            cyc_q <= op_cycles(wr_op);
          end
        end
        CTBE_ST_EXEC: begin
          if (last) begin
            state_q <= CTBE_ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        default: state_q <= CTBE_ST_IDLE;
      endcase
    end
  end

  always_comb begin
    sh_res = operand_q;
    sh_c = status_q[CTBE_FLAG_C];
    case (cmd_q.op)
      OP_SHIFT_LEFT_LOGICAL: begin
        sh_res = {operand_q[6:0], 1'b0};
        sh_c = operand_q[7];
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        sh_res = {1'b0, operand_q[7:1]};
        sh_c = operand_q[0];
      end
      OP_ROTATE_LEFT_CARRY: begin
        sh_res = {operand_q[6:0], status_q[CTBE_FLAG_C]};
        sh_c = operand_q[7];
      end
      OP_ROTATE_RIGHT_CARRY: begin
        sh_res = {status_q[CTBE_FLAG_C], operand_q[7:1]};
        sh_c = operand_q[0];
      end
      OP_ARITH_RIGHT_SHIFT: begin
        sh_res = {operand_q[7], operand_q[7:1]};
        sh_c = operand_q[0];
      end
      default: begin
        sh_res = operand_q;
        sh_c = status_q[CTBE_FLAG_C];
      end
    endcase
  end

  // Result register: destination of every register-bound operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= 8'h00;
    end else if (busy) begin
      case (cmd_q.op)
        OP_PROGMEM_BYTE_FETCH: if (cnt_q == 3'h1) result_q <= pm_rdata;
        OP_STACK_LOAD: if (last) result_q <= stk_rdata;
        OP_IO_READ: result_q <= io_rdata;
        OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY, OP_ARITH_RIGHT_SHIFT: result_q <= sh_res;
        OP_NIBBLE_SWAP: result_q <= {operand_q[3:0], operand_q[7:4]};
        OP_TRANSFER_FLAG_TO_REG_BIT: begin
          result_q <= operand_q;
          result_q[cmd_q.bit_idx] <= status_q[CTBE_FLAG_T];
        end
        default: result_q <= result_q;
      endcase
    end
  end

  // Status register; only the listed operations touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= CTBE_STATUS_RST;
    end else if (wr_acc && 8'(paddr) == CTBE_STATUS_OFS) begin
      status_q <= pwdata[7:0];
    end else if (busy) begin
      case (cmd_q.op)
        OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY, OP_ARITH_RIGHT_SHIFT: begin
          status_q[CTBE_FLAG_Z] <= (sh_res == 8'h00);
          status_q[CTBE_FLAG_C] <= sh_c;
          status_q[CTBE_FLAG_N] <= sh_res[7];
          status_q[CTBE_FLAG_V] <= sh_res[7] ^ sh_c;
        end
        OP_STATUS_BIT_RAISE_INDEXED: status_q[cmd_q.bit_idx] <= 1'b1;
        OP_STATUS_BIT_DROP_INDEXED: status_q[cmd_q.bit_idx] <= 1'b0;
        OP_REG_BIT_TO_TRANSFER_FLAG:
          status_q[CTBE_FLAG_T] <= operand_q[cmd_q.bit_idx];
        OP_CARRY_RAISE, OP_CARRY_DROP, OP_NEGATIVE_FLAG_RAISE, OP_NEGATIVE_FLAG_DROP,
        OP_ZERO_FLAG_RAISE, OP_ZERO_FLAG_DROP, OP_IRQ_GLOBAL_ALLOW, OP_IRQ_GLOBAL_BLOCK,
        OP_SIGN_FLAG_RAISE, OP_SIGN_FLAG_DROP, OP_OVERFLOW_FLAG_RAISE,
        OP_OVERFLOW_FLAG_DROP, OP_TRANSFER_FLAG_RAISE:
          // Odd codes raise, even codes drop
          status_q[flag_sel(cmd_q.op)] <= cmd_q.op[0];
        default: status_q <= status_q;
      endcase
    end
  end

  // Software-loaded operands; Z also advances after a byte fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zptr_q <= CTBE_ZPTR_RST;
    end else if (wr_acc && 8'(paddr) == CTBE_ZPTR_OFS) begin
      zptr_q <= pwdata[15:0];
    end else if (last && cmd_q.op == OP_PROGMEM_BYTE_FETCH) begin
      zptr_q <= zptr_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand_q <= 8'h00;
      word_q <= 16'h0000;
      ioaddr_q <= 6'h00;
    end else if (wr_acc) begin
      if (8'(paddr) == CTBE_OPERAND_OFS) operand_q <= pwdata[7:0];
      if (8'(paddr) == CTBE_WORD_OFS) word_q <= pwdata[15:0];
      if (8'(paddr) == CTBE_IOADDR_OFS) ioaddr_q <= pwdata[5:0];
    end
  end

  // Read-modify-write value for the I/O bit operations
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_mod_q <= 8'h00;
    end else if (busy && cnt_q == 3'h0) begin
      io_mod_q <= io_rdata;
      if (cmd_q.op == OP_IO_BIT_RAISE) io_mod_q[cmd_q.bit_idx] <= 1'b1;
      if (cmd_q.op == OP_IO_BIT_DROP) io_mod_q[cmd_q.bit_idx] <= 1'b0;
    end
  end

  // External strobes
  always_comb begin
    pm_req.rd_en = busy && cmd_q.op == OP_PROGMEM_BYTE_FETCH && cnt_q == 3'h0;
    pm_req.wr_en = busy && cmd_q.op == OP_PROGMEM_WORD_WRITE && cnt_q == 3'h0;
    pm_req.addr = zptr_q;
    pm_req.wdata = word_q;
    stk_push = busy && cmd_q.op == OP_STACK_STORE && cnt_q == 3'h0;
    stk_pop = busy && cmd_q.op == OP_STACK_LOAD && cnt_q == 3'h0;
    io_req.addr = ioaddr_q;
    io_req.rd_en = busy && cnt_q == 3'h0 && (cmd_q.op == OP_IO_READ ||
      cmd_q.op == OP_IO_BIT_RAISE || cmd_q.op == OP_IO_BIT_DROP);
    io_req.wr_en = busy && ((cmd_q.op == OP_IO_WRITE) ||
      (cnt_q == 3'h1 && (cmd_q.op == OP_IO_BIT_RAISE || cmd_q.op == OP_IO_BIT_DROP)));
    io_req.wdata = (cmd_q.op == OP_IO_WRITE) ? operand_q : io_mod_q;
  end

  assign stk_wdata = operand_q;

endmodule

// >>> rtl/ctbe_pkg.sv
// Constants and types shared by the transfer and bit-operation execution slice
package ctbe_pkg;

  // Register byte offsets
  localparam logic [7:0] CTBE_CMD_OFS = 8'h00;
  localparam logic [7:0] CTBE_OPERAND_OFS = 8'h04;
  localparam logic [7:0] CTBE_RESULT_OFS = 8'h08;
  localparam logic [7:0] CTBE_STATUS_OFS = 8'h0c;
  localparam logic [7:0] CTBE_ZPTR_OFS = 8'h10;
  localparam logic [7:0] CTBE_WORD_OFS = 8'h14;
  localparam logic [7:0] CTBE_IOADDR_OFS = 8'h18;

  // Command register field positions
  localparam int CTBE_CMD_OP_LSB = 0;
  localparam int CTBE_CMD_BIT_LSB = 8;
  localparam int CTBE_CMD_BUSY_BIT = 31;

  // Reset values
  localparam logic [7:0] CTBE_STATUS_RST = 8'h00;
  localparam logic [15:0] CTBE_ZPTR_RST = 16'h0000;

  // Status register bit positions
  localparam int CTBE_FLAG_C = 0;
  localparam int CTBE_FLAG_Z = 1;
  localparam int CTBE_FLAG_N = 2;
  localparam int CTBE_FLAG_V = 3;
  localparam int CTBE_FLAG_S = 4;
  localparam int CTBE_FLAG_H = 5;
  localparam int CTBE_FLAG_T = 6;
  localparam int CTBE_FLAG_I = 7;

  // Operation codes
  localparam logic [4:0] OP_PROGMEM_BYTE_FETCH = 5'h01;
  localparam logic [4:0] OP_PROGMEM_WORD_WRITE = 5'h02;
  localparam logic [4:0] OP_IO_READ = 5'h03;
  localparam logic [4:0] OP_IO_WRITE = 5'h04;
  localparam logic [4:0] OP_STACK_STORE = 5'h05;
  localparam logic [4:0] OP_STACK_LOAD = 5'h06;
  localparam logic [4:0] OP_IO_BIT_RAISE = 5'h07;
  localparam logic [4:0] OP_IO_BIT_DROP = 5'h08;
  localparam logic [4:0] OP_SHIFT_LEFT_LOGICAL = 5'h09;
  localparam logic [4:0] OP_SHIFT_RIGHT_LOGICAL = 5'h0a;
  localparam logic [4:0] OP_ROTATE_LEFT_CARRY = 5'h0b;
  localparam logic [4:0] OP_ROTATE_RIGHT_CARRY = 5'h0c;
  localparam logic [4:0] OP_ARITH_RIGHT_SHIFT = 5'h0d;
  localparam logic [4:0] OP_NIBBLE_SWAP = 5'h0e;
  localparam logic [4:0] OP_STATUS_BIT_RAISE_INDEXED = 5'h0f;
  localparam logic [4:0] OP_STATUS_BIT_DROP_INDEXED = 5'h10;
  localparam logic [4:0] OP_REG_BIT_TO_TRANSFER_FLAG = 5'h11;
  localparam logic [4:0] OP_TRANSFER_FLAG_TO_REG_BIT = 5'h12;
  localparam logic [4:0] OP_CARRY_RAISE = 5'h13;
  localparam logic [4:0] OP_CARRY_DROP = 5'h14;
  localparam logic [4:0] OP_NEGATIVE_FLAG_RAISE = 5'h15;
  localparam logic [4:0] OP_NEGATIVE_FLAG_DROP = 5'h16;
  localparam logic [4:0] OP_ZERO_FLAG_RAISE = 5'h17;
  localparam logic [4:0] OP_ZERO_FLAG_DROP = 5'h18;
  localparam logic [4:0] OP_IRQ_GLOBAL_ALLOW = 5'h19;
  localparam logic [4:0] OP_IRQ_GLOBAL_BLOCK = 5'h1a;
  localparam logic [4:0] OP_SIGN_FLAG_RAISE = 5'h1b;
  localparam logic [4:0] OP_SIGN_FLAG_DROP = 5'h1c;
  localparam logic [4:0] OP_OVERFLOW_FLAG_RAISE = 5'h1d;
  localparam logic [4:0] OP_OVERFLOW_FLAG_DROP = 5'h1e;
  localparam logic [4:0] OP_TRANSFER_FLAG_RAISE = 5'h1f;

  // Execution cycle counts
  localparam logic [2:0] CTBE_CYC_FETCH = 3'h3;
  localparam logic [2:0] CTBE_CYC_STACK = 3'h2;
  localparam logic [2:0] CTBE_CYC_IO_BIT = 3'h2;
  localparam logic [2:0] CTBE_CYC_SINGLE = 3'h1;
  localparam logic [2:0] CTBE_CYC_WORD_WRITE = 3'h2;

  typedef enum logic {CTBE_ST_IDLE, CTBE_ST_EXEC} ctbe_state_t;

  typedef struct packed {
    logic [2:0] bit_idx;
    logic [4:0] op;
  } ctbe_cmd_t;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ctbe_pm_req_t;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [5:0] addr;
    logic [7:0] wdata;
  } ctbe_io_req_t;

endpackage

// >>> verification/ctbe_far_model.sv
// Program memory, data stack and I/O space behind the slice
`timescale 1ns/1ps
module ctbe_far_model
  import ctbe_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Requests
  input wire ctbe_pm_req_t pm_req,
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire logic [7:0] stk_wdata,
  input wire ctbe_io_req_t io_req,
  // Answers
  output logic [7:0] pm_rdata,
  output logic [7:0] stk_rdata,
  output logic [7:0] io_rdata
);
  logic [7:0] stk_mem [16];
  logic [7:0] io_mem [64];
  logic [3:0] sp_q = 4'h0;
  logic [15:0] word_q = 16'h0000;
  logic [15:0] waddr_q = 16'h0000;
  initial begin
    pm_rdata = 8'h00;
    stk_rdata = 8'h00;
    for (int i = 0; i < 64; i++) io_mem[i] = 8'h00;
  end
  // Memory and stack answers are valid one cycle after the strobe and toggle otherwise; I/O data is valid with its strobe and inverted otherwise
  always @(posedge pclk) begin
    pm_rdata <= pm_req.rd_en ? pm_req.addr[7:0] ^ pm_req.addr[15:8] ^ 8'h5a : ~pm_rdata;
    stk_rdata <= stk_pop ? stk_mem[sp_q - 4'h1] : ~stk_rdata;
    if (pm_req.wr_en) begin
      word_q <= pm_req.wdata;
      waddr_q <= pm_req.addr;
    end
    if (stk_push) begin
      stk_mem[sp_q] <= stk_wdata;
      sp_q <= sp_q + 4'h1;
    end
    if (stk_pop) sp_q <= sp_q - 4'h1;
    if (io_req.wr_en) io_mem[io_req.addr] <= io_req.wdata;
  end
  assign io_rdata = io_req.rd_en ? io_mem[io_req.addr] : ~io_mem[io_req.addr];
endmodule

// >>> verification/ctbe_sva.sv
// Port checker for the execution slice
`timescale 1ns/1ps
module ctbe_sva
  import ctbe_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // Far side
  input wire ctbe_pm_req_t pm_req,
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire ctbe_io_req_t io_req,
  input wire logic [7:0] io_rdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] bidx_q;
  // Bit index of the last write access, accepted or refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bidx_q <= 3'h0;
    end else if (psel && penable && pwrite) begin
      bidx_q <= pwdata[10:8];
    end
  end
  sequence go(logic [4:0] op);
    psel && penable && pwrite && paddr == CTBE_CMD_OFS && pwdata[4:0] == op && !pslverr;
  endsequence
  sequence wr_setup;
    psel && !penable && pwrite;
  endsequence
  fetch_strobe_a: assert property (go(OP_PROGMEM_BYTE_FETCH) |=> pm_req.rd_en ##1 !pm_req.rd_en [*2])
    else $error("fetch strobe wrong");
  busy_refuse_a: assert property (go(OP_PROGMEM_BYTE_FETCH) ##1 wr_setup ##1 penable |-> pslverr)
    else $error("write during fetch accepted");
  push_strobe_a: assert property (go(OP_STACK_STORE) |=> stk_push && !stk_pop ##1 !stk_push)
    else $error("push strobe wrong");
  pop_strobe_a: assert property (go(OP_STACK_LOAD) |=> stk_pop && !stk_push ##1 !stk_pop)
    else $error("pop strobe wrong");
  io_raise_a: assert property (go(OP_IO_BIT_RAISE) |=> io_req.rd_en ##1 io_req.wr_en && io_req.wdata == ($past(io_rdata) | (8'h01 << bidx_q)))
    else $error("io bit raise wrong");
  io_drop_a: assert property (go(OP_IO_BIT_DROP) |=> io_req.rd_en ##1 io_req.wr_en && io_req.wdata == ($past(io_rdata) & ~(8'h01 << bidx_q)))
    else $error("io bit drop wrong");
  io_write_a: assert property (go(OP_IO_WRITE) |=> io_req.wr_en ##1 !io_req.wr_en)
    else $error("io write strobe wrong");
  word_write_a: assert property (go(OP_PROGMEM_WORD_WRITE) |=> pm_req.wr_en ##1 !pm_req.wr_en)
    else $error("word write strobe wrong");
endmodule
bind ctbe_exec ctbe_sva #(.ADDR_W(ADDR_W)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .pm_req(pm_req), .stk_push(stk_push), .stk_pop(stk_pop), .io_req(io_req), .io_rdata(io_rdata));

// >>> verification/tb_top.sv
// Self-checking bench for the execution slice
`timescale 1ns/1ps
module tb_top;
  import ctbe_pkg::*;
  localparam int FIDX [7] = '{CTBE_FLAG_C, CTBE_FLAG_N, CTBE_FLAG_Z, CTBE_FLAG_I,
    CTBE_FLAG_S, CTBE_FLAG_V, CTBE_FLAG_T};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, stk_push, stk_pop;
  logic [7:0] pm_rdata, stk_wdata, stk_rdata, io_rdata;
  ctbe_pm_req_t pm_req;
  ctbe_io_req_t io_req;
  int bad_count = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'd48;
  logic [31:0] rd;
  logic er;
  always #12.5 pclk = ~pclk;
  ctbe_exec #(.ADDR_W(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pm_req(pm_req), .pm_rdata(pm_rdata), .stk_push(stk_push),
    .stk_pop(stk_pop), .stk_wdata(stk_wdata), .stk_rdata(stk_rdata), .io_req(io_req),
    .io_rdata(io_rdata));
  ctbe_far_model mdl (.pclk(pclk), .pm_req(pm_req), .stk_push(stk_push), .stk_pop(stk_pop),
    .stk_wdata(stk_wdata), .io_req(io_req), .pm_rdata(pm_rdata), .stk_rdata(stk_rdata),
    .io_rdata(io_rdata));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] expf(input logic [4:0] op, input logic [2:0] b,
      input logic [7:0] x, input logic [7:0] s);
    logic [7:0] r;
    logic c;
    r = x;
    c = s[CTBE_FLAG_C];
    case (op)
      OP_SHIFT_LEFT_LOGICAL: {c, r} = {x, 1'b0};
      OP_SHIFT_RIGHT_LOGICAL: {r, c} = {1'b0, x};
      OP_ROTATE_LEFT_CARRY: {c, r} = {x, s[CTBE_FLAG_C]};
      OP_ROTATE_RIGHT_CARRY: {r, c} = {s[CTBE_FLAG_C], x};
      OP_ARITH_RIGHT_SHIFT: {r, c} = {x[7], x};
      OP_NIBBLE_SWAP: r = {x[3:0], x[7:4]};
      OP_STATUS_BIT_RAISE_INDEXED: s[b] = 1'b1;
      OP_STATUS_BIT_DROP_INDEXED: s[b] = 1'b0;
      OP_REG_BIT_TO_TRANSFER_FLAG: s[CTBE_FLAG_T] = x[b];
      OP_TRANSFER_FLAG_TO_REG_BIT: r[b] = s[CTBE_FLAG_T];
      default: s[FIDX[(op - 5'h13) >> 1]] = op[0];
    endcase
    if (op <= OP_ARITH_RIGHT_SHIFT) begin
      s[CTBE_FLAG_C] = c;
      s[CTBE_FLAG_Z] = (r == 8'h00);
      s[CTBE_FLAG_N] = r[7];
      s[CTBE_FLAG_V] = r[7] ^ c;
    end
    return {s, r};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge pclk);
    end
    if (k == 50) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask
  task automatic run(input logic [4:0] op, input logic [2:0] b);
    int k;
    k = 0;
    apb(1'b1, CTBE_CMD_OFS, {21'h0, b, 3'h0, op});
    apb(1'b0, CTBE_CMD_OFS, 32'h0);
    while (rd[CTBE_CMD_BUSY_BIT] !== 1'b0 && k < 20) begin
      k++;
      apb(1'b0, CTBE_CMD_OFS, 32'h0);
    end
    if (k == 20) bad_count++;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #(25 * 40000);
    bad_count++;
    finish_test;
  end
  initial begin
    logic [31:0] v, w, z, s;
    logic [15:0] e;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk(CTBE_STATUS_OFS, 32'h0);
    rchk(CTBE_ZPTR_OFS, 32'h0);
    $display("test reset done");
    for (int n = 0; n < 3; n++) begin
      for (int op = 9; op < 32; op++) begin
        v = (n == 0) ? rnd() : ((n == 1) ? 32'h80 : 32'h0);
        s = rnd();
        w = rnd();
        apb(1'b1, CTBE_OPERAND_OFS, {24'h0, v[7:0]});
        apb(1'b1, CTBE_STATUS_OFS, {24'h0, s[7:0]});
        run(op[4:0], w[2:0]);
        e = expf(op[4:0], w[2:0], v[7:0], s[7:0]);
        rchk(CTBE_STATUS_OFS, {24'h0, e[15:8]});
        if (op < 15 || op == 18) rchk(CTBE_RESULT_OFS, {24'h0, e[7:0]});
      end
    end
    $display("test flags done");
    z = rnd();
    z[7:0] = 8'hff;
    s = rnd();
    apb(1'b1, CTBE_ZPTR_OFS, {16'h0, z[15:0]});
    apb(1'b1, CTBE_STATUS_OFS, {24'h0, s[7:0]});
    run(OP_PROGMEM_BYTE_FETCH, 3'h0);
    rchk(CTBE_RESULT_OFS, {24'h0, z[7:0] ^ z[15:8] ^ 8'h5a});
    rchk(CTBE_ZPTR_OFS, {16'h0, z[15:0] + 16'h1});
    rchk(CTBE_STATUS_OFS, {24'h0, s[7:0]});
    apb(1'b1, CTBE_CMD_OFS, {27'h0, OP_PROGMEM_BYTE_FETCH});
    apb(1'b1, CTBE_OPERAND_OFS, 32'h0);
    chk({31'h0, er}, 32'h1);
    repeat (4) @(posedge pclk);
    $display("test fetch done");
    v = rnd();
    w = rnd();
    apb(1'b1, CTBE_OPERAND_OFS, {24'h0, v[7:0]});
    run(OP_STACK_STORE, 3'h0);
    apb(1'b1, CTBE_OPERAND_OFS, {24'h0, w[7:0]});
    run(OP_STACK_STORE, 3'h0);
    run(OP_STACK_LOAD, 3'h0);
    rchk(CTBE_RESULT_OFS, {24'h0, w[7:0]});
    run(OP_STACK_LOAD, 3'h0);
    rchk(CTBE_RESULT_OFS, {24'h0, v[7:0]});
    rchk(CTBE_STATUS_OFS, {24'h0, s[7:0]});
    $display("test stack done");
    z = rnd();
    apb(1'b1, CTBE_IOADDR_OFS, {26'h0, z[5:0]});
    apb(1'b1, CTBE_OPERAND_OFS, {24'h0, v[7:0]});
    run(OP_IO_WRITE, 3'h0);
    run(OP_IO_BIT_RAISE, w[2:0]);
    run(OP_IO_BIT_DROP, w[5:3]);
    run(OP_IO_READ, 3'h0);
    v[w[2:0]] = 1'b1;
    v[w[5:3]] = 1'b0;
    rchk(CTBE_RESULT_OFS, {24'h0, v[7:0]});
    rchk(CTBE_STATUS_OFS, {24'h0, s[7:0]});
    $display("test io done");
    apb(1'b1, CTBE_ZPTR_OFS, {16'h0, z[31:16]});
    apb(1'b1, CTBE_WORD_OFS, {16'h0, w[31:16]});
    run(OP_PROGMEM_WORD_WRITE, 3'h0);
    chk({mdl.waddr_q, mdl.word_q}, {z[31:16], w[31:16]});
    rchk(CTBE_STATUS_OFS, {24'h0, s[7:0]});
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, CTBE_CMD_OFS, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, CTBE_RESULT_OFS, 32'h5a);
    chk({31'h0, er}, 32'h1);
    $display("test refusals done");
    finish_test;
  end
endmodule
